// File: rtl/pxa_clk_div.sv
// pxa_clk_div: converter clock divider, one tick every 2^gain block clocks.
// assumes the gain holds steady between two starts.
`timescale 1ns/1ps
`default_nettype none
module pxa_clk_div (
  input wire logic i_clk,
  input wire logic i_rst_b,
  pxa_tmr_if.div tif
);
  import pxa_pkg::*;
  logic [6:0] cnt_q;

  // restart on start so the first tick lands a full period later
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 7'h00;
    end else if (tif.start) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= 7'(cnt_q + 7'h01);
    end
  end

  // no ceiling on gain: codes above 5 divide further
  assign tif.tick = !tif.start && ((cnt_q & gain_mask(tif.gain)) == gain_mask(tif.gain));
endmodule
`default_nettype wire

// File: rtl/pxa_config_bank.sv
// pxa_config_bank: converter configuration registers plus the measurement
// sequencer that applies them to proximity, ambient infrared and auxiliary runs.
// assumes an Avalon-MM master on byte addresses; only byte lane 0 carries data, except count bits 15:8 read on lane 1.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module pxa_config_bank #(
  parameter int PULSE_LEN = pxa_pkg::PULSE_TICKS
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_avs_response,
  input wire logic i_meas_req,
  input wire pxa_pkg::pxa_kind_t i_meas_kind,
  input wire logic [7:0] i_prox_input_code,
  output logic o_meas_ready,
  output logic o_meas_done,
  output logic [7:0] o_adc_input_code,
  output logic o_emitter_on,
  output logic o_adc_integrate,
  output logic o_adc_clk_tick,
  output logic o_high_range,
  output logic o_raw_mode,
  output logic [2:0] o_gain_exp
);
  import pxa_pkg::*;

  typedef enum logic [1:0] {
    PXA_IDLE,
    PXA_ARM,
    PXA_RUN,
    PXA_FIN
  } pxa_state_t;

  pxa_tmr_if tif ();

  // configuration storage, defined bits only
  logic [2:0] gain_q;
  logic range_q;
  logic mode_q;
  logic [7:0] amb_ir_q;
  logic [7:0] aux_q;

  // bus slave
  logic req;
  logic ack_q;
  logic [5:0] idx;
  logic hit;
  logic wr_en;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;

  // sequencer
  pxa_state_t state_q;
  pxa_state_t state_d;
  pxa_kind_t kind_q;
  logic [2:0] run_gain_q;
  logic run_raw_q;
  logic [7:0] code_q;
  logic emit_q;
  logic integ_q;
  logic range_run_q;
  logic done_q;
  logic start;
  logic [15:0] count_q;

  assign req = i_avs_read || i_avs_write;
  assign idx = i_avs_address[7:2];
  // one wait state: the answer stands at the edge after the first
  assign o_avs_waitrequest = req && !ack_q;
  assign wr_en = i_avs_write && ack_q && i_avs_byteenable[0];

  function automatic logic idx_known(input logic [5:0] a);
    idx_known = (a == IDX_GAIN) || (a == IDX_MISC) || (a == IDX_AMB_IR) ||
      (a == IDX_AUX) || (a == IDX_STATUS) || (a == IDX_COUNT);
  endfunction

  assign hit = idx_known(idx);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // gain exponent, no upper clamp: the host owns the safe range
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gain_q <= GAIN_RST;
    end else if (wr_en && idx == IDX_GAIN) begin
      gain_q <= i_avs_writedata[GAIN_LSB +: GAIN_W];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      range_q <= MISC_RST[MISC_RANGE_BIT];
      mode_q <= MISC_RST[MISC_MODE_BIT];
    end else if (wr_en && idx == IDX_MISC) begin
      range_q <= i_avs_writedata[MISC_RANGE_BIT];
      mode_q <= i_avs_writedata[MISC_MODE_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      amb_ir_q <= AMB_IR_RST;
    end else if (wr_en && idx == IDX_AMB_IR) begin
      amb_ir_q <= i_avs_writedata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aux_q <= AUX_RST;
    end else if (wr_en && idx == IDX_AUX) begin
      aux_q <= i_avs_writedata[7:0];
    end
  end

  // read mux; reserved bits read zero, and so do upper lanes except count bits 15:8
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (idx)
      IDX_GAIN: rdata_d[GAIN_LSB +: GAIN_W] = gain_q;
      IDX_MISC: begin
        rdata_d[MISC_RANGE_BIT] = range_q;
        rdata_d[MISC_MODE_BIT] = mode_q;
      end
      IDX_AMB_IR: rdata_d[7:0] = amb_ir_q;
      IDX_AUX: rdata_d[7:0] = aux_q;
      IDX_STATUS: rdata_d[7:0] = {1'b0, kind_q, state_q, emit_q, integ_q,
        tif.busy};
      IDX_COUNT: rdata_d[15:0] = count_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 32'h0000_0000;
      resp_q <= RESP_OKAY;
    end else if (req && !ack_q) begin
      rdata_q <= i_avs_read ? rdata_d : 32'h0000_0000;
      resp_q <= hit ? RESP_OKAY : RESP_DECODE;
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_response = resp_q;

  // sequencer state
  assign o_meas_ready = (state_q == PXA_IDLE);
  assign start = (state_q == PXA_ARM);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PXA_IDLE: if (i_meas_req) begin
        state_d = PXA_ARM;
      end
      PXA_ARM: state_d = PXA_RUN;
      PXA_RUN: if (tif.done) begin
        state_d = PXA_FIN;
      end
      PXA_FIN: state_d = PXA_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= PXA_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // settings are captured at request so a mid-run write cannot tear a measurement
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      kind_q <= KIND_PROX;
      run_gain_q <= GAIN_RST;
      run_raw_q <= 1'b0;
      range_run_q <= 1'b0;
      code_q <= AUX_RST;
    end else if (state_q == PXA_IDLE && i_meas_req) begin
      kind_q <= i_meas_kind;
      // only proximity runs take the exponent and range
      run_gain_q <= (i_meas_kind == KIND_PROX) ? gain_q : 3'h0;
      run_raw_q <= (i_meas_kind == KIND_PROX) && !mode_q;
      range_run_q <= (i_meas_kind == KIND_PROX) && range_q;
      unique case (i_meas_kind)
        KIND_PROX: code_q <= i_prox_input_code;
        KIND_AMB_IR: code_q <= amb_ir_q;
        KIND_AUX: code_q <= aux_q;
        KIND_REF: code_q <= CODE_NO_PD;
      endcase
    end
  end

  // timer drive: window length in converter ticks, stretched by the divider
  assign tif.start = start;
  assign tif.gain = run_gain_q;
  assign tif.len = TMR_W'(PULSE_LEN);

  pxa_clk_div u_div (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .tif(tif.div)
  );

  pxa_timer u_tmr (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .tif(tif.tmr)
  );

  // emitter only fires for normal proximity runs; raw mode just converts
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      emit_q <= 1'b0;
      integ_q <= 1'b0;
    end else if (start) begin
      emit_q <= (kind_q == KIND_PROX) && !run_raw_q;
      integ_q <= 1'b1;
    end else if (tif.done) begin
      emit_q <= 1'b0;
      integ_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == PXA_RUN) && tif.done;
    end
  end

  // wraps silently; software reads it as a progress counter
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_q <= 16'h0000;
    end else if ((state_q == PXA_RUN) && tif.done) begin
      count_q <= 16'(count_q + 16'h0001);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_adc_input_code <= AUX_RST;
      o_high_range <= 1'b0;
      o_raw_mode <= 1'b0;
      o_gain_exp <= GAIN_RST;
    end else begin
      o_adc_input_code <= code_q;
      o_high_range <= range_run_q;
      o_raw_mode <= run_raw_q;
      o_gain_exp <= run_gain_q;
    end
  end

  assign o_emitter_on = emit_q;
  assign o_adc_integrate = integ_q;
  // busy gate: at gain 0 the divider still ticks in the cycle done is reported
  assign o_adc_clk_tick = tif.tick && integ_q && tif.busy;
  assign o_meas_done = done_q;
endmodule
`default_nettype wire

// File: rtl/pxa_pkg.sv
// pxa_pkg: constants, types and helpers for the proximity/aux converter config bank.
// assumes a single 40 MHz clock and an Avalon-MM host with 32-bit data.
// How it works
// - 3-bit gain exponent in bits 2:0 stretches emitter pulse and integration by 2^exp.
// - converter clock is divided by 2^exp: 0 gives /1, 4 gives /16, 5 gives /32.
// - sequencer does no protective check; any programmed gain is carried out.
// - bit 5 selects high signal range, effective gain reduced by 14.5.
// - bit 2 chooses raw converter (0) or normal proximity (1) measurement.
// - proximity range and mode register resets to 0x04.
// - ambient infrared selector 0x00 picks small, 0x03 large infrared photodiode.
// - auxiliary selector 0x65 is temperature, 0x75 supply voltage, ground referenced.
// - auxiliary input selector resets to 0x65, temperature.
// - code 0x06 selects no photodiode, the reference reading for ambient results.
package pxa_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_GAIN = 6'h0b;
  localparam logic [5:0] IDX_MISC = 6'h0c;
  localparam logic [5:0] IDX_AMB_IR = 6'h0e;
  localparam logic [5:0] IDX_AUX = 6'h0f;
  localparam logic [5:0] IDX_STATUS = 6'h20;
  localparam logic [5:0] IDX_COUNT = 6'h21;
  // field positions
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 3;
  localparam int MISC_RANGE_BIT = 5;
  localparam int MISC_MODE_BIT = 2;
  // reset values
  localparam logic [2:0] GAIN_RST = 3'h0;
  localparam logic [7:0] MISC_RST = 8'h04;
  localparam logic [7:0] AMB_IR_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h65;
  // converter input codes
  localparam logic [7:0] CODE_SMALL_IR = 8'h00;
  localparam logic [7:0] CODE_LARGE_IR = 8'h03;
  localparam logic [7:0] CODE_NO_PD = 8'h06;
  localparam logic [7:0] CODE_TEMP = 8'h65;
  localparam logic [7:0] CODE_VDD = 8'h75;
  // timing: base emitter pulse, counted in converter ticks at gain 0
  localparam int CLK_PERIOD_NS = 25;
  localparam int PULSE_NS = 25600;
  localparam int PULSE_TICKS = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 11;
  // avalon response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECODE = 2'h3;

  typedef enum logic [1:0] {
    KIND_PROX,
    KIND_AMB_IR,
    KIND_AUX,
    KIND_REF
  } pxa_kind_t;

  // low-bit mask of the divider counter for a given exponent
  function automatic logic [6:0] gain_mask(input logic [2:0] exp_v);
    gain_mask = 7'(({7'h00, 1'b1} << exp_v) - 8'h01);
  endfunction
endpackage

// File: rtl/pxa_timer.sv
// pxa_timer: counts converter ticks for one emitter pulse / integration window.
// assumes len is stable while start is high.
`timescale 1ns/1ps
`default_nettype none
module pxa_timer (
  input wire logic i_clk,
  input wire logic i_rst_b,
  pxa_tmr_if.tmr tif
);
  import pxa_pkg::*;
  logic [TMR_W-1:0] cnt_q;
  logic busy_q;
  logic done_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (tif.start) begin
      cnt_q <= tif.len;
      busy_q <= 1'b1;
    end else if (busy_q && tif.tick) begin
      cnt_q <= TMR_W'(cnt_q - 1'b1);
      if (cnt_q == TMR_W'(1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && tif.tick && (cnt_q == TMR_W'(1)) && !tif.start;
    end
  end

  assign tif.busy = busy_q;
  assign tif.done = done_q;
endmodule
`default_nettype wire

// File: rtl/pxa_tmr_if.sv
// pxa_tmr_if: carrier between the sequencer, converter clock divider and duration timer.
// assumes all three parties share the block clock.
`timescale 1ns/1ps
`default_nettype none
interface pxa_tmr_if;
  logic start;
  logic [2:0] gain;
  logic [pxa_pkg::TMR_W-1:0] len;
  logic tick;
  logic done;
  logic busy;
  modport seq (output start, output gain, output len, input tick, input done, input busy);
  modport div (input start, input gain, output tick);
  modport tmr (input start, input len, input tick, output done, output busy);
endinterface
`default_nettype wire

// File: test/pxa_config_bank_props.sv
// pxa_config_bank_props: port-level checks of the config bank.
// assumes it is bound onto pxa_config_bank; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pxa_config_bank_props #(
  parameter int PULSE_LEN = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_meas_done,
  input wire logic o_emitter_on,
  input wire logic o_adc_integrate,
  input wire logic o_adc_clk_tick,
  input wire logic o_raw_mode,
  input wire logic [2:0] o_gain_exp
);
  logic [7:0] gap_q;
  logic seen_q;
  logic [15:0] len_q;
  logic rd_end;
  assign rd_end = i_avs_read && !o_avs_waitrequest;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gap_q <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      gap_q <= o_adc_clk_tick ? 8'h01 : gap_q + 8'h01;
      seen_q <= o_adc_integrate && (seen_q || o_adc_clk_tick);
    end
  end
  // window length in block clocks, held in the cycle integrate falls
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) len_q <= 16'h0;
    else len_q <= o_adc_integrate ? len_q + 16'h1 : 16'h0;
  end
  chk_wait_once: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("waitrequest held too long");
  chk_gain_rsvd: assert property (rd_end && i_avs_address[7:2] == 6'h0b
    |-> o_avs_readdata[31:3] == 29'h0) else $error("gain reserved bits set");
  chk_misc_rsvd: assert property (rd_end && i_avs_address[7:2] == 6'h0c
    |-> (o_avs_readdata & ~32'h24) == 32'h0) else $error("misc reserved bits set");
  chk_tick_gap: assert property (o_adc_clk_tick && seen_q
    |-> gap_q == (8'h01 << o_gain_exp)) else $error("tick spacing wrong");
  chk_raw_dark: assert property (o_raw_mode |-> !o_emitter_on)
    else $error("emitter on in raw mode");
  chk_emit_inside: assert property (o_emitter_on |-> o_adc_integrate)
    else $error("emitter outside window");
  chk_window_len: assert property ($fell(o_adc_integrate)
    |-> len_q + 2 >= (PULSE_LEN << o_gain_exp) && len_q <= (PULSE_LEN << o_gain_exp) + 2)
    else $error("window length wrong");
  chk_done_follow: assert property ($fell(o_adc_integrate) |-> ##[0:2] o_meas_done)
    else $error("no done after window");
endmodule
`default_nettype wire

// File: test/pxa_config_bank_test.sv
// pxa_config_bank_test: register and measurement checks of the config bank.
// assumes pxa_host as bus master; the bench drives the measurement port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end
module pxa_config_bank_test;
  import pxa_pkg::*;
  localparam int PL = 8;
  logic i_clk, i_rst_b, i_avs_read, i_avs_write, o_avs_waitrequest, hang;
  logic [7:0] i_avs_address, i_prox_input_code, o_adc_input_code;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  logic [3:0] i_avs_byteenable;
  logic [1:0] o_avs_response;
  logic i_meas_req, o_meas_ready, o_meas_done, o_emitter_on, o_adc_integrate;
  logic o_adc_clk_tick, o_high_range, o_raw_mode;
  logic [2:0] o_gain_exp;
  pxa_kind_t i_meas_kind;
  int bad_count = 0;
  int samples_checked = 0;
  logic [7:0] adr [4] = '{8'h2c, 8'h30, 8'h38, 8'h3c};
  logic [31:0] msk [4] = '{32'h7, 32'h24, 32'hff, 32'hff};
  logic [31:0] sh [4] = '{32'h0, 32'h04, 32'h0, 32'h65};
  pxa_config_bank #(.PULSE_LEN(PL)) pxa_config_bank_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_avs_response(o_avs_response), .i_meas_req(i_meas_req), .i_meas_kind(i_meas_kind),
    .i_prox_input_code(i_prox_input_code), .o_meas_ready(o_meas_ready),
    .o_meas_done(o_meas_done), .o_adc_input_code(o_adc_input_code),
    .o_emitter_on(o_emitter_on), .o_adc_integrate(o_adc_integrate),
    .o_adc_clk_tick(o_adc_clk_tick), .o_high_range(o_high_range), .o_raw_mode(o_raw_mode),
    .o_gain_exp(o_gain_exp));
  pxa_host pxa_host_inst (.i_clk(i_clk), .i_wait(o_avs_waitrequest),
    .i_rdata(o_avs_readdata), .i_resp(o_avs_response), .o_addr(i_avs_address),
    .o_rd(i_avs_read), .o_wr(i_avs_write), .o_wdata(i_avs_writedata),
    .o_be(i_avs_byteenable), .o_hang(hang));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge hang) begin
    bad_count++;
    results();
  end
  function automatic logic [31:0] exp_rd(int i, logic [31:0] d);
    logic [31:0] m;
    m = d & msk[i];
    if (i == 0 && m > 32'h5) m = 32'h5;
    return m;
  endfunction
  task automatic wr(int i, logic [31:0] d);
    logic [31:0] q;
    logic [1:0] r;
    pxa_host_inst.xfer(1'b0, adr[i], d, 4'h1, q, r);
    sh[i] = exp_rd(i, d);
  endtask
  task automatic chk_rd(int i);
    logic [31:0] q;
    logic [1:0] r;
    pxa_host_inst.xfer(1'b1, adr[i], 32'h0, 4'hf, q, r);
    `CHK("register", sh[i], q)
    `CHK("response", RESP_OKAY, r)
  endtask
  task automatic run(pxa_kind_t k, logic [7:0] ec, logic [2:0] eg, logic er, logic ew,
      logic ee);
    int n, t;
    logic e;
    @(posedge i_clk);
    i_meas_req <= 1'b1;
    i_meas_kind <= k;
    i_prox_input_code <= ec;
    @(posedge i_clk);
    i_meas_req <= 1'b0;
    i_prox_input_code <= ~ec;
    n = 0;
    t = 0;
    e = 1'b0;
    do begin
      @(negedge i_clk);
      n++;
      if (o_adc_clk_tick === 1'b1) t++;
      e = e | o_emitter_on;
    end while (o_meas_done !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      bad_count++;
      results();
    end
    `CHK("ticks", PL, t)
    `CHK("code", ec, o_adc_input_code)
    `CHK("gain", eg, o_gain_exp)
    `CHK("range", er, o_high_range)
    `CHK("raw", ew, o_raw_mode)
    `CHK("emitter", ee, e)
    `CHK("ready low", 1'b0, o_meas_ready)
    @(negedge i_clk);
    `CHK("ready back", 1'b1, o_meas_ready)
  endtask
  initial begin
    logic [31:0] q;
    logic [1:0] r;
    logic [7:0] v;
    i_rst_b = 1'b0;
    i_meas_req = 1'b0;
    i_meas_kind = KIND_PROX;
    i_prox_input_code = 8'h00;
    void'($urandom(32'h3a95cc29));
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) chk_rd(i);
    for (int j = 0; j < 16; j++) begin
      wr(j % 4, $urandom);
      chk_rd(j % 4);
    end
    pxa_host_inst.xfer(1'b0, adr[3], 32'h12, 4'he, q, r);
    chk_rd(3);
    pxa_host_inst.xfer(1'b1, 8'h44, 32'h0, 4'hf, q, r);
    `CHK("decode", 2'h3, r)
    `CHK("decode data", 32'h0, q)
    v = 8'($urandom);
    wr(0, 0);
    wr(1, 32'h04);
    run(KIND_PROX, v, 3'h0, 1'b0, 1'b0, 1'b1);
    wr(0, 4);
    wr(1, 32'h24);
    run(KIND_PROX, v, 3'h4, 1'b1, 1'b0, 1'b1);
    wr(0, 5);
    wr(1, 32'hdb);
    run(KIND_PROX, v, 3'h5, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wr(2, i * 3);
      run(KIND_AMB_IR, 8'(i * 3), 3'h0, 1'b0, 1'b0, 1'b0);
      wr(3, 32'h75 - i * 16);
      run(KIND_AUX, 8'h75 - 8'(i * 16), 3'h0, 1'b0, 1'b0, 1'b0);
    end
    run(KIND_REF, CODE_NO_PD, 3'h0, 1'b0, 1'b0, 1'b0);
    results();
  end
endmodule
bind pxa_config_bank pxa_config_bank_props #(.PULSE_LEN(PULSE_LEN)) props_inst (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_meas_done(o_meas_done),
  .o_emitter_on(o_emitter_on), .o_adc_integrate(o_adc_integrate),
  .o_adc_clk_tick(o_adc_clk_tick), .o_raw_mode(o_raw_mode), .o_gain_exp(o_gain_exp));
`default_nettype wire

// File: test/pxa_host.sv
// pxa_host: avalon-mm master standing in for the configuring host.
// assumes the bench calls xfer; one request at a time.
`timescale 1ns/1ps
`default_nettype none
module pxa_host (
  input wire logic i_clk,
  input wire logic i_wait,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_resp,
  output logic [7:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [31:0] o_wdata,
  output logic [3:0] o_be,
  output logic o_hang
);
  logic [2:0] rec_q;
  initial begin
    rec_q = 3'h7;
    o_addr = 8'h00;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 32'h0;
    o_be = 4'h0;
    o_hang = 1'b0;
  end
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q, output logic [1:0] r);
    int n;
    if (!rd && a[7:2] == 6'h0b && d[2:0] > 3'h5) d[2:0] = 3'h5;
    if (!rd && a[7:2] == 6'h0b) rec_q = ~d[2:0];
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= rd;
    o_wr <= !rd;
    o_wdata <= d;
    o_be <= be;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_wait !== 1'b0 && n < 20);
    if (i_wait !== 1'b0) o_hang <= 1'b1;
    q = i_rdata;
    r = i_resp;
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    // released lines show no stale value
    o_wdata <= ~d;
    o_addr <= ~a;
  endtask
endmodule
`default_nettype wire
